// *** rtl/atsr_pkg.sv ***
// constants and types of the async timer status, interrupt and wake registers
// How it works
// - timer counts and raises events only while the enable bit is one
// - counter value register reads and writes the 32-bit count, resets to zero
// - while busy, writes to control, counter, clear and wake registers are dropped
// - while busy, counter and wake-enable registers read as zero
// - writing the clock control register sets clock-busy until the clock settles
// - clock-settled flag sets when clock-busy falls, cleared by status clear
// - ready flag sets when busy falls, cleared by status clear
// - periodic flags set on rising edge of their prescaler bit, sticky
// - match flags set when counter reaches its alarm value, sticky
// - wrap flag sets when the counter overflows, sticky until cleared
// - writing one to a status clear bit clears flag and its request
// - writing one to an irq enable set bit sets that mask bit
// - writing one to an irq enable clear bit clears that mask bit
// - irq enable state register reads back the mask
// - wake enable register gates which events drive the wake output
// - interrupt request stands while any flag is set with its mask bit
// - synchronised writes take several cycles, busy stays high meanwhile
package atsr_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_COUNTER = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_CLEAR = 8'h0c;
   localparam logic [7:0] OFS_IRQ_SET = 8'h10;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATE = 8'h18;
   localparam logic [7:0] OFS_WAKE = 8'h1c;
   localparam logic [7:0] OFS_CLOCK = 8'h40;
   // ****************************************
   // field positions and masks
   // ****************************************
   localparam int BIT_ENABLE = 0;
   localparam int BIT_CLK_ON = 0;
   localparam int BIT_WRAP = 0;
   localparam int BIT_MATCH0 = 8;
   localparam int BIT_MATCH1 = 9;
   localparam int BIT_PERIODIC_EVENT_0 = 16;
   localparam int BIT_PERIODIC_EVENT_1 = 17;
   localparam int BIT_BUSY = 24;
   localparam int BIT_READY = 25;
   localparam int BIT_PRESCALER_CLOCK_SWITCHING = 28;
   localparam int BIT_PRESCALER_CLOCK_SETTLED = 29;
   localparam logic [31:0] FLAG_MASK = 32'h2203_0301;
   localparam logic [31:0] WAKE_MASK = 32'h0003_0301;
   localparam logic [31:0] CONTROL_MASK = 32'h0000_0001;
   localparam logic [31:0] CLOCK_MASK = 32'h0000_0001;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [31:0] COUNT_MAX = 32'hffff_ffff;
   localparam logic [31:0] COUNT_ONE = 32'h0000_0001;
   // ****************************************
   // timing
   // ****************************************
   localparam int SYNC_CYCLES_DEFAULT = 4;
   localparam int CLK_SETTLE_DEFAULT = 8;
   typedef enum logic [1:0] {TGT_CONTROL, TGT_COUNTER, TGT_CLEAR, TGT_WAKE} atsr_target_t;
endpackage

// *** rtl/atsr_regs.sv ***
// register file, status flags, interrupt and wake logic of the async timer
`timescale 1ns/1ns
module atsr_regs
   import atsr_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int SYNC_CYCLES = SYNC_CYCLES_DEFAULT,
   parameter int CLK_SETTLE = CLK_SETTLE_DEFAULT
) (
   // clock, reset, freeze
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clkEn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // timer events: prescaler tick and periodic bits from the prescaler domain
   input wire logic prescTick,
   input wire logic [1:0] periodicBit,
   // alarm comparators, same clock
   input wire logic [1:0] matchHit,
   // system side
   output logic [31:0] counterValue,
   output logic timerEnabled,
   output logic prescClockOn,
   output logic irqReq,
   output logic wakeReq
);
   localparam int SW = $clog2(SYNC_CYCLES + 1);
   localparam int CW = $clog2(CLK_SETTLE + 1);
   localparam logic [SW-1:0] SYNC_LOAD = SW'(SYNC_CYCLES);
   localparam logic [SW-1:0] SYNC_ONE = SW'(1);
   localparam logic [CW-1:0] CLK_LOAD = CW'(CLK_SETTLE);
   localparam logic [CW-1:0] CLK_ONE = CW'(1);

   initial begin
      if (ADDR_W < 8 || SYNC_CYCLES < 1 || CLK_SETTLE < 1) begin
         $error("atsr_regs: ADDR_W >= 8, SYNC_CYCLES >= 1, CLK_SETTLE >= 1 required");
      end
   end

   // ****************************************
   // input synchronisers
   // ****************************************
   logic [2:0] syncA_q;
   logic [2:0] syncB_q;
   logic [2:0] syncPrev_q;
   logic [1:0] matchPrev_q;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         syncA_q <= 3'h0;
         syncB_q <= 3'h0;
         syncPrev_q <= 3'h0;
         matchPrev_q <= 2'h0;
      end else if (clkEn) begin
         syncA_q <= {periodicBit, prescTick};
         syncB_q <= syncA_q;
         syncPrev_q <= syncB_q;
         matchPrev_q <= matchHit;
      end
   end

   logic tickRise;
   logic [1:0] perRise;
   logic [1:0] matchRise;
   assign tickRise = syncB_q[0] & ~syncPrev_q[0];
   assign perRise = syncB_q[2:1] & ~syncPrev_q[2:1];
   assign matchRise = matchHit & ~matchPrev_q;

   // ****************************************
   // apb access decode
   // ****************************************
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [7:0] ofs;
   logic accessNow;
   logic wrNow;
   logic mapped;
   assign ofs = paddr[7:0];
   assign accessNow = clkEn & psel & penable & pready_q;
   assign wrNow = accessNow & pwrite & ~pslverr_q;

   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      logic ok;
      ok = (a[7:0] == OFS_CONTROL) || (a[7:0] == OFS_COUNTER) || (a[7:0] == OFS_STATUS) ||
           (a[7:0] == OFS_CLEAR) || (a[7:0] == OFS_IRQ_SET) || (a[7:0] == OFS_IRQ_CLR) ||
           (a[7:0] == OFS_IRQ_STATE) || (a[7:0] == OFS_WAKE) || (a[7:0] == OFS_CLOCK);
      return ok && ((a >> 8) == '0);
   endfunction
   assign mapped = isMapped(paddr);

   // ****************************************
   // synchronised write path
   // ****************************************
   logic [SW-1:0] busyCnt_q;
   atsr_target_t pendTgt_q;
   logic [31:0] pendData_q;
   logic busy;
   logic applyNow;
   logic syncWrite;
   assign busy = busyCnt_q != '0;
   assign applyNow = clkEn & (busyCnt_q == SYNC_ONE);
   assign syncWrite = wrNow & ~busy &
                      ((ofs == OFS_CONTROL) || (ofs == OFS_COUNTER) ||
                       (ofs == OFS_CLEAR) || (ofs == OFS_WAKE));

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         busyCnt_q <= '0;
         pendTgt_q <= TGT_CONTROL;
         pendData_q <= RESET_WORD;
      end else if (clkEn) begin
         if (syncWrite) begin
            busyCnt_q <= SYNC_LOAD;
            pendData_q <= pwdata;
            unique case (ofs)
               OFS_COUNTER: pendTgt_q <= TGT_COUNTER;
               OFS_CLEAR: pendTgt_q <= TGT_CLEAR;
               OFS_WAKE: pendTgt_q <= TGT_WAKE;
               default: pendTgt_q <= TGT_CONTROL;
            endcase
         end else if (busy) begin
            busyCnt_q <= busyCnt_q - SYNC_ONE;
         end
      end
   end

   // ****************************************
   // control, wake enable, clock control
   // ****************************************
   logic [31:0] control_q;
   logic [31:0] wake_q;
   logic [31:0] clockCtl_q;
   logic [31:0] clockPend_q;
   logic [CW-1:0] clkBusyCnt_q;
   logic prescaler_clock_switching;
   logic enabled;
   assign prescaler_clock_switching = clkBusyCnt_q != '0;
   assign enabled = control_q[BIT_ENABLE];

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         control_q <= RESET_WORD;
         wake_q <= RESET_WORD;
      end else if (applyNow && pendTgt_q == TGT_CONTROL) begin
         control_q <= pendData_q & CONTROL_MASK;
      end else if (applyNow && pendTgt_q == TGT_WAKE) begin
         wake_q <= pendData_q & WAKE_MASK;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         clkBusyCnt_q <= '0;
         clockCtl_q <= RESET_WORD;
         clockPend_q <= RESET_WORD;
      end else if (clkEn) begin
         if (wrNow && ofs == OFS_CLOCK && !prescaler_clock_switching) begin
            clkBusyCnt_q <= CLK_LOAD;
            clockPend_q <= pwdata & CLOCK_MASK;
         end else if (prescaler_clock_switching) begin
            clkBusyCnt_q <= clkBusyCnt_q - CLK_ONE;
            if (clkBusyCnt_q == CLK_ONE) begin
               clockCtl_q <= clockPend_q;
            end
         end
      end
   end

   // ****************************************
   // counter
   // ****************************************
   logic [31:0] count_q;
   logic wrapEvt;
   assign wrapEvt = clkEn & enabled & tickRise & (count_q == COUNT_MAX);

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         count_q <= RESET_WORD;
      end else if (applyNow && pendTgt_q == TGT_COUNTER) begin
         count_q <= pendData_q;
      end else if (clkEn && enabled && tickRise) begin
         count_q <= count_q + COUNT_ONE;
      end
   end

   // ****************************************
   // status flags and mask
   // ****************************************
   logic [31:0] flags_q;
   logic [31:0] mask_q;
   logic [31:0] setVec;
   logic [31:0] clrVec;
   logic busyPrev_q;
   logic clkBusyPrev_q;

   always_comb begin
      setVec = RESET_WORD;
      setVec[BIT_WRAP] = wrapEvt;
      setVec[BIT_MATCH0] = clkEn & enabled & matchRise[0];
      setVec[BIT_MATCH1] = clkEn & enabled & matchRise[1];
      setVec[BIT_PERIODIC_EVENT_0] = clkEn & enabled & perRise[0];
      setVec[BIT_PERIODIC_EVENT_1] = clkEn & enabled & perRise[1];
      setVec[BIT_READY] = clkEn & busyPrev_q & ~busy;
      setVec[BIT_PRESCALER_CLOCK_SETTLED] = clkEn & clkBusyPrev_q & ~prescaler_clock_switching;
      clrVec = (applyNow && pendTgt_q == TGT_CLEAR) ? (pendData_q & FLAG_MASK) : RESET_WORD;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         flags_q <= RESET_WORD;
         busyPrev_q <= 1'b0;
         clkBusyPrev_q <= 1'b0;
      end else if (clkEn) begin
         // a new event wins over a clear in the same cycle
         flags_q <= ((flags_q & ~clrVec) | setVec) & FLAG_MASK;
         busyPrev_q <= busy;
         clkBusyPrev_q <= prescaler_clock_switching;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         mask_q <= RESET_WORD;
      end else if (wrNow && ofs == OFS_IRQ_SET) begin
         mask_q <= mask_q | (pwdata & FLAG_MASK);
      end else if (wrNow && ofs == OFS_IRQ_CLR) begin
         mask_q <= mask_q & ~pwdata;
      end
   end

   // ****************************************
   // read data and bus answer
   // ****************************************
   logic [31:0] statusWord;
   logic [31:0] readWord;
   always_comb begin
      statusWord = flags_q;
      statusWord[BIT_BUSY] = busy;
      statusWord[BIT_PRESCALER_CLOCK_SWITCHING] = prescaler_clock_switching;
      readWord = RESET_WORD;
      unique case (ofs)
         OFS_CONTROL: readWord = busy ? RESET_WORD : control_q;
         OFS_COUNTER: readWord = busy ? RESET_WORD : count_q;
         OFS_STATUS: readWord = statusWord;
         OFS_IRQ_STATE: readWord = mask_q;
         OFS_WAKE: readWord = busy ? RESET_WORD : wake_q;
         OFS_CLOCK: readWord = clockCtl_q;
         default: readWord = RESET_WORD;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         prdata_q <= RESET_WORD;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (clkEn) begin
         if (psel && !penable) begin
            pready_q <= 1'b1;
            pslverr_q <= ~mapped;
            prdata_q <= (pwrite || !mapped) ? RESET_WORD : readWord;
         end else if (accessNow) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= RESET_WORD;
         end
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   logic irq_q;
   logic wake_out_q;
   logic [31:0] countOut_q;
   logic enOut_q;
   logic clkOnOut_q;
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         irq_q <= 1'b0;
         wake_out_q <= 1'b0;
         countOut_q <= RESET_WORD;
         enOut_q <= 1'b0;
         clkOnOut_q <= 1'b0;
      end else if (clkEn) begin
         irq_q <= |(flags_q & mask_q);
         // wake holds until software clears the flag
         wake_out_q <= |(flags_q & wake_q);
         countOut_q <= count_q;
         enOut_q <= enabled;
         clkOnOut_q <= clockCtl_q[BIT_CLK_ON];
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irqReq = irq_q;
   assign wakeReq = wake_out_q;
   assign counterValue = countOut_q;
   assign timerEnabled = enOut_q;
   assign prescClockOn = clkOnOut_q;

   // ****************************************
   // assertions
   // ****************************************
   // masked flags that keep a request pending
   logic [31:0] irqPend;
   assign irqPend = flags_q & mask_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   busy_write_drop_a: assert property (clkEn && wrNow && busy |=>
      busyCnt_q == $past(busyCnt_q) - SYNC_ONE)
      else $error("write accepted while busy");
   busy_read_zero_a: assert property (clkEn && psel && !penable && !pwrite && busy &&
      (ofs == OFS_COUNTER || ofs == OFS_WAKE) |=> prdata_q == RESET_WORD)
      else $error("busy read not zero");
   count_halt_a: assert property (!enabled && !(applyNow && pendTgt_q == TGT_COUNTER)
      |=> count_q == $past(count_q))
      else $error("counter moved while disabled");
   clk_busy_set_a: assert property (clkEn && wrNow && ofs == OFS_CLOCK && !prescaler_clock_switching
      |=> prescaler_clock_switching [*4])
      else $error("clock busy not held");
   clk_ready_set_a: assert property (clkEn && clkBusyPrev_q && !prescaler_clock_switching
      |=> flags_q[BIT_PRESCALER_CLOCK_SETTLED])
      else $error("clock settled flag not set");
   ready_set_a: assert property (clkEn && busyPrev_q && !busy |=> flags_q[BIT_READY])
      else $error("ready flag not set");
   wrap_set_a: assert property (wrapEvt |=> flags_q[BIT_WRAP] && count_q == RESET_WORD)
      else $error("wrap not flagged");
   period_set_a: assert property (clkEn && enabled && perRise[0] |=> flags_q[BIT_PERIODIC_EVENT_0])
      else $error("periodic flag not set");
   match_set_a: assert property (clkEn && enabled && matchRise[1] |=> flags_q[BIT_MATCH1])
      else $error("match flag not set");
   flag_clear_a: assert property (clkEn && clrVec[BIT_MATCH0] && !setVec[BIT_MATCH0]
      |=> !flags_q[BIT_MATCH0] ##1 (irq_q == (|$past(irqPend)) || !$past(clkEn)))
      else $error("clear did not drop flag and request");
   mask_set_a: assert property (wrNow && ofs == OFS_IRQ_SET && pwdata[BIT_PERIODIC_EVENT_1]
      |=> mask_q[BIT_PERIODIC_EVENT_1])
      else $error("mask bit not set");
   mask_clear_a: assert property (wrNow && ofs == OFS_IRQ_CLR && pwdata[BIT_WRAP]
      |=> !mask_q[BIT_WRAP])
      else $error("mask bit not cleared");
   irq_follow_a: assert property (clkEn && |(flags_q & mask_q) |=> irq_q)
      else $error("request missing");
   reserved_zero_a: assert property (pready_q && ofs == OFS_STATUS
      |-> (prdata_q & ~(FLAG_MASK | 32'h1100_0000)) == RESET_WORD)
      else $error("reserved bits not zero");
   // dropped writes leave the pending transfer untouched
   pend_hold_a: assert property (clkEn && wrNow && busy
      |=> pendData_q == $past(pendData_q) && pendTgt_q == $past(pendTgt_q))
      else $error("pending write overwritten while busy");
   clk_write_drop_a: assert property (clkEn && wrNow && ofs == OFS_CLOCK && prescaler_clock_switching
      |=> clockPend_q == $past(clockPend_q))
      else $error("clock write accepted while clock busy");
   ctrl_read_zero_a: assert property (clkEn && psel && !penable && !pwrite && busy &&
      ofs == OFS_CONTROL |=> prdata_q == RESET_WORD)
      else $error("busy control read not zero");

   busy_write_c: cover property (syncWrite ##[1:8] setVec[BIT_READY]);
   wrap_c: cover property (wrapEvt);
   wake_c: cover property (wake_out_q && !irq_q);
   clk_settle_c: cover property (setVec[BIT_PRESCALER_CLOCK_SETTLED]);
   freeze_c: cover property (!clkEn && enabled);
endmodule // atsr_regs

// *** testbench/atsr_tb.sv ***
// self-checking bench for the async timer status, interrupt and wake registers
`timescale 1ns/1ns
module testbench;
   import atsr_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic clkEn = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic prescTick = 1'b0;
   logic [1:0] periodicBit = 2'b00;
   logic [1:0] matchHit = 2'b00;
   logic [31:0] counterValue;
   logic timerEnabled;
   logic prescClockOn;
   logic irqReq;
   logic wakeReq;
   int err_count = 0;
   int cmp_count = 0;
   logic [31:0] rdata;
   logic rerr;

   always #10 core_clk = ~core_clk;

   // longer sync window leaves room to hit the busy state from the bus
   atsr_regs #(.ADDR_W(8), .SYNC_CYCLES(12), .CLK_SETTLE(8)) dut (
      .core_clk(core_clk), .rstn(rstn), .clkEn(clkEn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prescTick(prescTick), .periodicBit(periodicBit), .matchHit(matchHit),
      .counterValue(counterValue), .timerEnabled(timerEnabled),
      .prescClockOn(prescClockOn), .irqReq(irqReq), .wakeReq(wakeReq)
   );

   // ****************************************
   // tasks
   // ****************************************
   task automatic print_verdict();
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer: setup, then access held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         $display("wrong value at %0t: no bus answer", $time);
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rdata, exp);
   endtask

   // poll status until neither busy flag stands
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         xfer(1'b0, OFS_STATUS, 32'h0);
         n++;
      end while ((rdata & 32'h1100_0000) !== 32'h0 && n < 40);
      if (n >= 40) begin
         err_count++;
         $display("wrong value at %0t: busy never fell", $time);
      end
   endtask

   task automatic tick();
      prescTick <= 1'b1;
      repeat (6) @(posedge core_clk);
      prescTick <= 1'b0;
      repeat (6) @(posedge core_clk);
   endtask

   task automatic events(input logic [1:0] per, input logic [1:0] hit);
      periodicBit <= per;
      matchHit <= hit;
      repeat (8) @(posedge core_clk);
      periodicBit <= 2'b00;
      matchHit <= 2'b00;
      repeat (4) @(posedge core_clk);
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      rdc(OFS_COUNTER, 32'h0);
      rdc(OFS_STATUS, 32'h0);
      rdc(OFS_IRQ_STATE, 32'h0);
      rdc(OFS_WAKE, 32'h0);
      xfer(1'b0, 8'h44, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      wr(8'h44, 32'hffff_ffff);
      chk({31'h0, rerr}, 32'h1);
      wr(OFS_IRQ_SET, 32'hffff_ffff);
      rdc(OFS_IRQ_STATE, 32'h2203_0301);
      wr(OFS_IRQ_CLR, 32'h2200_0000);
      rdc(OFS_IRQ_STATE, 32'h0003_0301);
      wr(OFS_IRQ_SET, 32'h0);
      wr(OFS_IRQ_CLR, 32'h0);
      wr(OFS_IRQ_STATE, 32'hffff_ffff);
      rdc(OFS_IRQ_STATE, 32'h0003_0301);
      // counter write, then reads and a wake write while the sync runs
      wr(OFS_COUNTER, 32'h1234_5678);
      xfer(1'b0, OFS_STATUS, 32'h0);
      chk(rdata & 32'h0100_0000, 32'h0100_0000);
      rdc(OFS_COUNTER, 32'h0);
      wr(OFS_WAKE, 32'h0000_0001);
      wait_idle();
      rdc(OFS_COUNTER, 32'h1234_5678);
      rdc(OFS_WAKE, 32'h0);
      rdc(OFS_STATUS, 32'h0200_0000);
      wr(OFS_IRQ_SET, 32'h0200_0000);
      repeat (3) @(posedge core_clk);
      chk({31'h0, irqReq}, 32'h1);
      wr(OFS_IRQ_CLR, 32'h0200_0000);
      repeat (3) @(posedge core_clk);
      chk({31'h0, irqReq}, 32'h0);
      // timer enabled: counting, wrap, events, wake
      wr(OFS_CONTROL, 32'hffff_ffff);
      rdc(OFS_CONTROL, 32'h0);
      wait_idle();
      rdc(OFS_CONTROL, 32'h0000_0001);
      chk({31'h0, timerEnabled}, 32'h1);
      tick();
      rdc(OFS_COUNTER, 32'h1234_5679);
      chk(counterValue, 32'h1234_5679);
      wr(OFS_WAKE, 32'hffff_ffff);
      wait_idle();
      rdc(OFS_WAKE, 32'h0003_0301);
      wr(OFS_COUNTER, 32'hffff_ffff);
      wait_idle();
      chk({31'h0, wakeReq}, 32'h0);
      tick();
      rdc(OFS_COUNTER, 32'h0);
      rdc(OFS_STATUS, 32'h0200_0001);
      chk({31'h0, wakeReq}, 32'h1);
      chk({31'h0, irqReq}, 32'h1);
      // frozen clock enable: a tick in the meantime is never seen
      clkEn <= 1'b0;
      tick();
      clkEn <= 1'b1;
      rdc(OFS_COUNTER, 32'h0);
      chk(counterValue, 32'h0);
      events(2'b01, 2'b10);
      rdc(OFS_STATUS, 32'h0201_0201);
      events(2'b10, 2'b01);
      rdc(OFS_STATUS, 32'h0203_0301);
      wr(OFS_CLEAR, 32'h0002_0200);
      wait_idle();
      rdc(OFS_STATUS, 32'h0201_0101);
      wr(OFS_CLEAR, 32'h0001_0101);
      wait_idle();
      rdc(OFS_STATUS, 32'h0200_0000);
      chk({31'h0, irqReq}, 32'h0);
      chk({31'h0, wakeReq}, 32'h0);
      // timer disabled: no counting, no events
      wr(OFS_CONTROL, 32'h0);
      wait_idle();
      chk({31'h0, timerEnabled}, 32'h0);
      tick();
      events(2'b11, 2'b11);
      rdc(OFS_COUNTER, 32'h0);
      rdc(OFS_STATUS, 32'h0200_0000);
      // prescaler clock switch
      wr(OFS_CLOCK, 32'h0000_0001);
      xfer(1'b0, OFS_STATUS, 32'h0);
      chk(rdata & 32'h1000_0000, 32'h1000_0000);
      wr(OFS_CLOCK, 32'h0);
      wait_idle();
      chk({31'h0, prescClockOn}, 32'h1);
      rdc(OFS_CLOCK, 32'h0000_0001);
      rdc(OFS_STATUS, 32'h2200_0000);
      wr(OFS_IRQ_SET, 32'h2000_0000);
      repeat (3) @(posedge core_clk);
      chk({31'h0, irqReq}, 32'h1);
      wr(OFS_IRQ_CLR, 32'h0000_0001);
      rdc(OFS_IRQ_STATE, 32'h2003_0300);
      print_verdict();
   end

   initial begin
      #200000;
      err_count++;
      print_verdict();
   end
endmodule // testbench
